// ===== sim/sbr_flush_model.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_flush_model
	import sbr_seq_pkg::*;
#(
	parameter int DLY = 3
)
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic [NUM_DS_PORTS-1:0] flush_req,
	output var  logic [NUM_DS_PORTS-1:0] flush_done
);
	// queues take time to drain, so done never answers at once
	int cnt [NUM_DS_PORTS];

	always_ff @(posedge clk or negedge rst_n)
	begin
		for (int i = 0; i < NUM_DS_PORTS; i++)
		begin
			if (!rst_n || !flush_req[i])
			begin
				cnt[i] <= 0;
				flush_done[i] <= 1'b0;
			end
			else
			begin
				cnt[i] <= cnt[i] + 1;
				flush_done[i] <= (cnt[i] >= DLY);
			end
		end
	end
endmodule // sbr_flush_model

`default_nettype wire

// ===== sim/secondary_bus_reset_ctl_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_seq_sva
	import sbr_seq_pkg::*;
(
	input wire logic                    REF_CLK,
	input wire logic                    RESET_N,
	input wire logic                    US_SEC_RESET,
	input wire logic [NUM_DS_PORTS-1:0] DS_SEC_RESET,
	input wire logic [NUM_DS_PORTS-1:0] TS1_HOT_RESET,
	input wire logic [NUM_DS_PORTS-1:0] GO_DETECT,
	input wire logic [NUM_DS_PORTS-1:0] FLUSH_REQ,
	input wire logic [NUM_DS_PORTS-1:0] REG_INIT,
	input wire logic [NUM_DS_PORTS-1:0] CORE_RESET,
	input wire logic [NUM_DS_PORTS-1:0] PORT_HELD,
	input wire logic [NUM_DS_PORTS-1:0] DS_SEC_UR,
	input wire logic [NUM_DS_PORTS-1:0] SMB_REG_DEFAULT,
	input wire logic [NUM_DS_PORTS-1:0] PORT_RESET_BUSY,
	input wire logic                    US_SEC_UR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_ts1_len: assert property ($rose(TS1_HOT_RESET[0]) |-> ##19 TS1_HOT_RESET[0] ##1 !TS1_HOT_RESET[0])
		else $error("ts1 length wrong");
	a_disabled_no_ts1: assert property ((GO_DETECT & TS1_HOT_RESET) == '0)
		else $error("hot reset on disabled link");
	a_flush_follows: assert property ($fell(TS1_HOT_RESET[0]) |-> FLUSH_REQ[0])
		else $error("no flush after ts1");
	a_init_after_flush: assert property ($fell(FLUSH_REQ[0]) |-> REG_INIT[0] && CORE_RESET[0])
		else $error("no init after flush");
	a_held_after_core: assert property ($rose(PORT_HELD[0]) |-> CORE_RESET[0] && $past(CORE_RESET[0], 9))
		else $error("held before core reset done");
	a_us_ur: assert property (US_SEC_RESET |=> US_SEC_UR)
		else $error("upstream ur missing");
	a_ds_ur_steps: assert property (DS_SEC_UR == (TS1_HOT_RESET | FLUSH_REQ | REG_INIT))
		else $error("ur differs from active reset steps");
	a_smb_steps: assert property (SMB_REG_DEFAULT == (TS1_HOT_RESET | FLUSH_REQ | CORE_RESET))
		else $error("smb default differs from active reset steps");
	a_ds_start: assert property ($rose(DS_SEC_RESET[0]) && !PORT_RESET_BUSY[0]
		|=> PORT_RESET_BUSY[0] && (TS1_HOT_RESET[0] || FLUSH_REQ[0]))
		else $error("downstream reset not started");
endmodule // sbr_seq_sva

bind secondary_bus_reset_ctl sbr_seq_sva chk (.REF_CLK, .RESET_N, .US_SEC_RESET, .DS_SEC_RESET,
	.TS1_HOT_RESET, .GO_DETECT, .FLUSH_REQ, .REG_INIT, .CORE_RESET, .PORT_HELD, .DS_SEC_UR,
	.SMB_REG_DEFAULT, .PORT_RESET_BUSY, .US_SEC_UR);

`default_nettype wire

// ===== sim/tb_secondary_bus_reset_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_secondary_bus_reset_ctl
	import sbr_seq_pkg::*;
;
	typedef logic [NUM_DS_PORTS-1:0] vec_t;
	typedef struct { int p; logic lu; logic dis; logic e_ts1; logic e_det; } row_s;
	vec_t ds_rst, mc_start, link_up, ltssm_dis, flush_done;
	vec_t ts1, go_det, flush_req, reg_init, core_rst, held, ds_ur, smb_def, busy;
	logic ref_clk, reset_n, us_rst, us_ur;
	logic [NUM_DS_PORTS*MODE_ACT_W-1:0] mc_act;
	int miscompares, cmp_count, cycles;
	row_s rows [4] = '{'{0, 1, 0, 1, 0}, '{1, 0, 0, 0, 0}, '{5, 1, 1, 0, 1}, '{7, 0, 1, 0, 1}};

	secondary_bus_reset_ctl dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .US_SEC_RESET(us_rst),
		.DS_SEC_RESET(ds_rst), .MODE_CHG_START(mc_start), .MODE_CHG_ACTION(mc_act),
		.LINK_UP(link_up), .LTSSM_IN_DISABLED(ltssm_dis), .FLUSH_DONE(flush_done),
		.TS1_HOT_RESET(ts1), .GO_DETECT(go_det), .FLUSH_REQ(flush_req), .REG_INIT(reg_init),
		.CORE_RESET(core_rst), .PORT_HELD(held), .DS_SEC_UR(ds_ur), .SMB_REG_DEFAULT(smb_def),
		.PORT_RESET_BUSY(busy), .US_SEC_UR(us_ur));

	sbr_flush_model #(.DLY(3)) model (.clk(ref_clk), .rst_n(reset_n), .flush_req(flush_req),
		.flush_done(flush_done));

	task automatic chk(input string n, input vec_t e, input vec_t s);
		cmp_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wait_held(input vec_t e);
		for (int i = 0; i < 100 && held !== e; i++)
			@(negedge ref_clk);
		chk("held", e, held);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end

	initial
	begin
		{reset_n, us_rst, ds_rst, mc_start, mc_act, link_up, ltssm_dis} = '0;
		repeat (11) @(negedge ref_clk);
		reset_n = 1'b1;
		foreach (rows[k])
		begin
			vec_t b;
			b = vec_t'(1) << rows[k].p;
			link_up = rows[k].lu ? b : '0;
			ltssm_dis = rows[k].dis ? b : '0;
			// link status settles through the synchroniser before the request
			repeat (5) @(negedge ref_clk);
			ds_rst = b;
			@(negedge ref_clk);
			chk("ts1", rows[k].e_ts1 ? b : '0, ts1);
			chk("go_det", rows[k].e_det ? b : '0, go_det);
			chk("ds_ur", b, ds_ur);
			chk("smb", b, smb_def);
			@(negedge ref_clk);
			chk("go_det_end", '0, go_det);
			wait_held(b);
			chk("init", b, reg_init & core_rst);
			chk("busy", b, busy);
			ds_rst = '0;
			repeat (2) @(negedge ref_clk);
			chk("idle", '0, busy);
			$display("row %0d done", k);
		end
		link_up = '1;
		ltssm_dis = '0;
		repeat (5) @(negedge ref_clk);
		us_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("us_ts1", '1, ts1);
		chk("us_ur", vec_t'(1), vec_t'(us_ur));
		wait_held('1);
		repeat (10) @(negedge ref_clk);
		chk("us_hold", '1, held);
		us_rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("us_idle", '0, busy);
		chk("us_ur_off", '0, vec_t'(us_ur));
		$display("upstream test done");
		// port 1 action is not reset, so only port 3 may start
		mc_act[7:6] = MODE_ACT_RESET;
		mc_start = 8'h0A;
		@(negedge ref_clk);
		mc_start = '0;
		@(negedge ref_clk);
		chk("mode", 8'h08, busy);
		wait_held(8'h08);
		@(negedge ref_clk);
		chk("mode_idle", '0, busy);
		$display("mode test done");
		// port 6 link down, so its request goes straight to flush
		link_up = 8'hBF;
		repeat (5) @(negedge ref_clk);
		ds_rst = 8'h40;
		@(negedge ref_clk);
		chk("pre_flush", 8'h40, flush_req);
		reset_n = 1'b0;
		@(negedge ref_clk);
		chk("rst_busy", '0, busy);
		chk("rst_flush", '0, flush_req);
		// the bit stays set across release and counts as a fresh write
		reset_n = 1'b1;
		@(negedge ref_clk);
		chk("rel_busy", 8'h40, busy);
		@(negedge ref_clk);
		chk("rel_flush", 8'h40, flush_req);
		$display("reset test done");
		stop_test();
	end
endmodule // tb_secondary_bus_reset_ctl

`default_nettype wire

// ===== verilog/sbr_seq_pkg.sv
package sbr_seq_pkg;

	// number of downstream ports served by one partition sequencer
	localparam int unsigned NUM_DS_PORTS  = 8;

	localparam int unsigned CLK_PERIOD_NS = 100;

	// time that hot-reset training sets are sent before the next step
	localparam int unsigned TS1_HOLD_NS   = 2000;
	// time that stack and core logic of a port are held in graceful reset
	localparam int unsigned CORE_RST_NS   = 1000;

	localparam int unsigned TMR_W         = 8;

	// least times round up to whole cycles
	localparam logic [TMR_W-1:0] TS1_CYCLES =
		TMR_W'((TS1_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] CORE_RST_CYCLES =
		TMR_W'((CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
	localparam logic [TMR_W-1:0] TMR_ONE  = 8'h01;

	// mode change action field
	localparam int unsigned      MODE_ACT_W     = 2;
	localparam logic [MODE_ACT_W-1:0] MODE_ACT_RESET = 2'h1;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_PROP  = 3'h1,
		ST_FLUSH = 3'h2,
		ST_CRST  = 3'h3,
		ST_HOLD  = 3'h4
	} sbr_state_e;

endpackage

// ===== verilog/sbr_step_timer.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_step_timer
	import sbr_seq_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic [TMR_W-1:0] cycles,
	output wire logic             done
);

	logic [TMR_W-1:0] cnt_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= TMR_ZERO;
		else if (start)
			cnt_r <= cycles;
		else if (cnt_r != TMR_ZERO)
			cnt_r <= cnt_r - TMR_ONE;
	end

	// one-cycle pulse on the last counted cycle
	assign done = (cnt_r == TMR_ONE) && !start;

endmodule // sbr_step_timer

`default_nettype wire

// ===== verilog/secondary_bus_reset_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module secondary_bus_reset_ctl
	import sbr_seq_pkg::*;
(
	input  wire logic                               REF_CLK,
	input  wire logic                               RESET_N,
	input  wire logic                               US_SEC_RESET,
	input  wire logic [NUM_DS_PORTS-1:0]            DS_SEC_RESET,
	input  wire logic [NUM_DS_PORTS-1:0]            MODE_CHG_START,
	input  wire logic [NUM_DS_PORTS*MODE_ACT_W-1:0] MODE_CHG_ACTION,
	input  wire logic [NUM_DS_PORTS-1:0]            LINK_UP,
	input  wire logic [NUM_DS_PORTS-1:0]            LTSSM_IN_DISABLED,
	input  wire logic [NUM_DS_PORTS-1:0]            FLUSH_DONE,
	output wire logic [NUM_DS_PORTS-1:0]            TS1_HOT_RESET,
	output wire logic [NUM_DS_PORTS-1:0]            GO_DETECT,
	output wire logic [NUM_DS_PORTS-1:0]            FLUSH_REQ,
	output wire logic [NUM_DS_PORTS-1:0]            REG_INIT,
	output wire logic [NUM_DS_PORTS-1:0]            CORE_RESET,
	output wire logic [NUM_DS_PORTS-1:0]            PORT_HELD,
	output wire logic [NUM_DS_PORTS-1:0]            DS_SEC_UR,
	output wire logic [NUM_DS_PORTS-1:0]            SMB_REG_DEFAULT,
	output wire logic [NUM_DS_PORTS-1:0]            PORT_RESET_BUSY,
	output logic                                    US_SEC_UR
);

	logic                    us_lvl_d_r;
	logic                    us_rise;
	logic [NUM_DS_PORTS-1:0] ds_lvl_d_r;
	logic [NUM_DS_PORTS-1:0] cause_us_vec;
	logic [NUM_DS_PORTS-1:0] lu_s1_r;
	logic [NUM_DS_PORTS-1:0] lu_s2_r;
	logic [NUM_DS_PORTS-1:0] lu_s3_r;
	logic [NUM_DS_PORTS-1:0] lu_diff;
	logic [NUM_DS_PORTS-1:0] lu_r;
	logic [NUM_DS_PORTS-1:0] dis_s1_r;
	logic [NUM_DS_PORTS-1:0] dis_s2_r;
	logic [NUM_DS_PORTS-1:0] dis_s3_r;
	logic [NUM_DS_PORTS-1:0] dis_diff;
	logic [NUM_DS_PORTS-1:0] dis_r;

	// link status comes from the phy clock domain; a change is taken once stages two and three agree
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			lu_s1_r <= '0;
			lu_s2_r <= '0;
			lu_s3_r <= '0;
		end
		else
		begin
			lu_s1_r <= LINK_UP;
			lu_s2_r <= lu_s1_r;
			lu_s3_r <= lu_s2_r;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			dis_s1_r <= '0;
			dis_s2_r <= '0;
			dis_s3_r <= '0;
		end
		else
		begin
			dis_s1_r <= LTSSM_IN_DISABLED;
			dis_s2_r <= dis_s1_r;
			dis_s3_r <= dis_s2_r;
		end
	end

	assign lu_diff  = lu_s2_r ^ lu_s3_r;
	assign dis_diff = dis_s2_r ^ dis_s3_r;

	// a bit still moving between the stages keeps its last settled value
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			lu_r <= '0;
		else
			lu_r <= (lu_s3_r & ~lu_diff) | (lu_r & lu_diff);
	end

	// same settling for the disabled flag, so no port is judged on half-moved status
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			dis_r <= '0;
		else
			dis_r <= (dis_s3_r & ~dis_diff) | (dis_r & dis_diff);
	end

	// the control bits come from the register file on this clock, no sync needed
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			us_lvl_d_r <= 1'b0;
		else
			us_lvl_d_r <= US_SEC_RESET;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			ds_lvl_d_r <= '0;
		else
			ds_lvl_d_r <= DS_SEC_RESET;
	end

	// a write of one is seen as the bit going from clear to set
	assign us_rise = US_SEC_RESET && !us_lvl_d_r;

	// the upstream port itself is never reset here, its link and type 0 config are not gated
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			US_SEC_UR <= 1'b0;
		else
			US_SEC_UR <= US_SEC_RESET || (|cause_us_vec);
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DS_PORTS; gi = gi + 1)
		begin : g_port
			sbr_state_e       state_r;
			sbr_state_e       state_nxt;
			logic             cause_us_r;
			logic             cause_us_nxt;
			logic             cause_ds_r;
			logic             cause_ds_nxt;
			logic             ds_rise;
			logic             mc_trig;
			logic             trig;
			logic             hold_need;
			logic             tmr_start;
			logic [TMR_W-1:0] tmr_cycles;
			logic             tmr_done;
			logic             detect_nxt;
			logic             ts1_r;
			logic             detect_r;
			logic             reg_init_r;
			logic             core_rst_r;
			logic             held_r;
			logic             busy_r;

			assign ds_rise = DS_SEC_RESET[gi] && !ds_lvl_d_r[gi];
			assign mc_trig = MODE_CHG_START[gi] &&
				(MODE_CHG_ACTION[gi*MODE_ACT_W +: MODE_ACT_W] == MODE_ACT_RESET);
			// only this port's bit, its own mode change start and the upstream bit reach this port
			assign trig = us_rise || ds_rise || mc_trig;

			// mode change reset has no bit to wait on and resumes after its steps
			assign hold_need = (cause_us_r && US_SEC_RESET) || (cause_ds_r && DS_SEC_RESET[gi]);

			sbr_step_timer u_timer
			(
				.clk    (REF_CLK),
				.rst_n  (RESET_N),
				.start  (tmr_start),
				.cycles (tmr_cycles),
				.done   (tmr_done)
			);

			always_comb
			begin
				state_nxt    = state_r;
				tmr_start    = 1'b0;
				tmr_cycles   = TS1_CYCLES;
				detect_nxt   = 1'b0;
				cause_us_nxt = cause_us_r || us_rise;
				cause_ds_nxt = cause_ds_r || ds_rise;
				unique case (state_r)
					ST_IDLE, ST_HOLD:
					begin
						if (trig)
						begin
							// a new request during hold restarts the whole sequence
							if (lu_r[gi] && !dis_r[gi])
							begin
								state_nxt = ST_PROP;
								tmr_start = 1'b1;
							end
							else
							begin
								detect_nxt = dis_r[gi];
								state_nxt  = ST_FLUSH;
							end
						end
						else if (state_r == ST_HOLD && !hold_need)
						begin
							state_nxt    = ST_IDLE;
							cause_us_nxt = 1'b0;
							cause_ds_nxt = 1'b0;
						end
					end
					ST_PROP:
					begin
						if (tmr_done)
							state_nxt = ST_FLUSH;
					end
					ST_FLUSH:
					begin
						if (FLUSH_DONE[gi])
						begin
							state_nxt  = ST_CRST;
							tmr_start  = 1'b1;
							tmr_cycles = CORE_RST_CYCLES;
						end
					end
					ST_CRST:
					begin
						// the bit is looked at only once every step is over
						if (tmr_done)
							state_nxt = ST_HOLD;
					end
					default:
					begin
						state_nxt    = ST_IDLE;
						cause_us_nxt = 1'b0;
						cause_ds_nxt = 1'b0;
					end
				endcase
			end

			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					state_r <= ST_IDLE;
				else
					state_r <= state_nxt;
			end

			// set wins over clear: a trigger in the exit cycle keeps its cause
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					cause_us_r <= 1'b0;
				else
					cause_us_r <= cause_us_nxt;
			end

			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					cause_ds_r <= 1'b0;
				else
					cause_ds_r <= cause_ds_nxt;
			end

			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					ts1_r <= 1'b0;
				else
					ts1_r <= (state_nxt == ST_PROP);
			end

			// one pulse is enough for the link to leave Disabled
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					detect_r <= 1'b0;
				else
					detect_r <= detect_nxt;
			end

			// the register file keeps sticky fields itself; this only asks for the init
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					reg_init_r <= 1'b0;
				else
					reg_init_r <= (state_nxt == ST_CRST) || (state_nxt == ST_HOLD);
			end

			// core reset stays on through hold so nothing restarts before the bit clears
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					core_rst_r <= 1'b0;
				else
					core_rst_r <= (state_nxt == ST_CRST) || (state_nxt == ST_HOLD);
			end

			// held marks that every step is over and only the bit is awaited
			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					held_r <= 1'b0;
				else
					held_r <= (state_nxt == ST_HOLD);
			end

			always_ff @(posedge REF_CLK or negedge RESET_N)
			begin
				if (!RESET_N)
					busy_r <= 1'b0;
				else
					busy_r <= (state_nxt != ST_IDLE);
			end

			assign TS1_HOT_RESET[gi]   = ts1_r;
			assign GO_DETECT[gi]       = detect_r;
			// flush is a handshake held until the queues report empty
			assign FLUSH_REQ[gi]       = (state_r == ST_FLUSH);
			assign REG_INIT[gi]        = reg_init_r;
			assign CORE_RESET[gi]      = core_rst_r;
			assign PORT_HELD[gi]       = held_r;
			// config type 0 to the port itself is not in this flag, it still completes
			assign DS_SEC_UR[gi]       = busy_r;
			assign SMB_REG_DEFAULT[gi] = busy_r;
			assign PORT_RESET_BUSY[gi] = busy_r;
			assign cause_us_vec[gi]    = cause_us_r;
		end
	endgenerate

endmodule // secondary_bus_reset_ctl

`default_nettype wire
